//--- design/cmfs_ctrl.sv
// Purpose: Mode selection and fail-safe transmitter gating for a high-speed CAN transceiver
// Assumes: Supply-good and temperature flags are digital, txd and bus level synchronous to mclk
// Notes: Registers over AXI4-Lite; dominant timeout length is a parameter for short sims
// Operation
// - Digital supply up: pick normal, receive-only or forced
// - Digital supply lost: power-down from any mode
// - Mode select read only with digital supply
// - Normal with mode select high: receive-only
// - Normal or receive-only needs transmitter supply
// - Transmitter supply loss: block, forced receive-only
// - Forced mode keeps receiving, watches transmitter supply
// - Supply back, mode select low: normal
// - Open pins: select low, txd high
// - Long dominant txd disables transmitter
// - Receiver stays active during dominant timeout
// - Only txd rising edge releases timeout
// - Overtemperature disables transmitter, normal mode only
// - Cooling down re-enables transmitter automatically
// - Dominant timeout between 1 and 4 ms
// - Forced mode: ground bias, no timeout, overtemperature
// - Receive-only modes ignore txd
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module cmfs_ctrl
    import cmfs_pkg::*;
#(
    parameter int DOM_TO_LIMIT = DOM_TO_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Supply and temperature monitors
    input wire logic digitalSupplyGood,
    input wire logic transmitterSupplyGood,
    input wire logic overTempIn,
    // Protocol controller side
    input wire logic modeSelectIn,
    input wire logic txdIn,
    output logic rxdOut,
    // Bus receiver comparator
    input wire logic busDominantIn,
    // Analog front end controls
    output cmfs_afe_s afeOut,
    // Register bus
    input wire cmfs_axi_req_s axiReq,
    output cmfs_axi_rsp_s axiRsp
);

    // Whole module state
    typedef struct packed {
        cmfs_mode_e mode;
        logic [DOM_CNT_W-1:0] domCnt;  // Cycles txd has stayed low
        logic domTo;                   // Dominant timeout latched
        logic txdPrev;                 // Txd in the previous cycle
        logic toSeen;                  // Sticky timeout record
        logic ctrlRxOnly;              // Software receive-only request
        logic rxd;
        cmfs_afe_s afe;
        logic awSeen;
        logic [ADDR_W-1:0] awAddr;
        logic wSeen;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } cmfs_state_s;

    cmfs_state_s st_r;   // Registered state
    cmfs_state_s st_nxt; // Next state
    logic [3:0] syncVec; // Synchronised monitors
    logic vioS;          // Digital supply good
    logic vccS;          // Transmitter supply good
    logic otS;           // Overtemperature
    logic msS;           // Mode select pin
    logic selHigh;       // Effective mode select
    logic awHs;
    logic wHs;
    logic arHs;
    logic [31:0] statusWord;
    localparam logic [DOM_CNT_W-1:0] DOM_LIM = DOM_CNT_W'(DOM_TO_LIMIT - 1);

    // Monitor and mode select synchronisers
    cmfs_sync #(.W(4), .RST_VAL(SYNC_RST_VAL)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn({overTempIn, modeSelectIn, transmitterSupplyGood, digitalSupplyGood}),
        .syncOut(syncVec)
    );
    assign vioS = syncVec[0];
    assign vccS = syncVec[1];
    assign msS = syncVec[2];
    assign otS = syncVec[3];
    // Register bit can also request receive-only
    assign selHigh = msS | st_r.ctrlRxOnly;

    // Bus handshakes
    assign awHs = axiReq.awvalid & ~st_r.awSeen & ~st_r.bValid;
    assign wHs = axiReq.wvalid & ~st_r.wSeen & ~st_r.bValid;
    assign arHs = axiReq.arvalid & ~st_r.rValid;

    // Status word
    always_comb begin
        statusWord = RDATA_ZERO;
        statusWord[STAT_MODE_LSB +: 2] = st_r.mode;
        statusWord[STAT_TXEN_BIT] = st_r.afe.txEnable;
        statusWord[STAT_DOMTO_BIT] = st_r.domTo;
        statusWord[STAT_OT_BIT] = otS;
        statusWord[STAT_TOSEEN_BIT] = st_r.toSeen;
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        // Mode machine; without digital supply nothing else is looked at
        if (!vioS) begin
            st_nxt.mode = MODE_PWRDN;
        end else begin
            unique case (st_r.mode)
                MODE_PWRDN: begin
                    // Power-up choice
                    if (!vccS) begin
                        st_nxt.mode = MODE_FORCED;
                    end else if (selHigh) begin
                        st_nxt.mode = MODE_RXONLY;
                    end else begin
                        st_nxt.mode = MODE_NORMAL;
                    end
                end
                MODE_NORMAL: begin
                    if (!vccS) begin
                        st_nxt.mode = MODE_FORCED;
                    end else if (selHigh) begin
                        st_nxt.mode = MODE_RXONLY;
                    end
                end
                MODE_RXONLY: begin
                    if (!vccS) begin
                        st_nxt.mode = MODE_FORCED;
                    end else if (!selHigh) begin
                        st_nxt.mode = MODE_NORMAL;
                    end
                end
                MODE_FORCED: begin
                    // Leave only once the transmitter supply is back
                    if (vccS) begin
                        st_nxt.mode = selHigh ? MODE_RXONLY : MODE_NORMAL;
                    end
                end
            endcase
        end
        // Dominant timeout counts only in normal mode
        st_nxt.txdPrev = txdIn;
        if (st_r.mode == MODE_NORMAL && !txdIn) begin
            if (st_r.domCnt == DOM_LIM) begin
                st_nxt.domTo = 1'b1;
            end else begin
                st_nxt.domCnt = st_r.domCnt + 1'b1;
            end
        end else begin
            st_nxt.domCnt = '0;
        end
        // Only a low-to-high txd edge releases the transmitter
        if (txdIn && !st_r.txdPrev) begin
            st_nxt.domTo = 1'b0;
        end
        // Front end controls from the next mode
        st_nxt.afe.rxOn = (st_nxt.mode != MODE_PWRDN);
        st_nxt.afe.biasHalf = (st_nxt.mode == MODE_NORMAL) || (st_nxt.mode == MODE_RXONLY);
        st_nxt.afe.biasGnd = (st_nxt.mode == MODE_FORCED);
        // Overtemperature gates only in normal mode, releases when the flag drops
        st_nxt.afe.txEnable = (st_nxt.mode == MODE_NORMAL) && !st_nxt.domTo && !otS;
        // Txd reaches the bus only while enabled
        st_nxt.afe.txDrive = st_nxt.afe.txEnable && !txdIn;
        // Receive output follows the bus whenever the receiver is on
        st_nxt.rxd = st_nxt.afe.rxOn ? !busDominantIn : 1'b1;
        // Write channel capture
        if (awHs) begin
            st_nxt.awSeen = 1'b1;
            st_nxt.awAddr = axiReq.awaddr;
        end
        if (wHs) begin
            st_nxt.wSeen = 1'b1;
            st_nxt.wData = axiReq.wdata;
            st_nxt.wStrb = axiReq.wstrb;
        end
        // Response retires on bready
        if (st_r.bValid && axiReq.bready) begin
            st_nxt.bValid = 1'b0;
        end
        // Write commit, then sticky timeout record: a new timeout beats a clear in the same cycle
        if (st_r.awSeen && st_r.wSeen && !st_r.bValid) begin
            st_nxt.awSeen = 1'b0;
            st_nxt.wSeen = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = RESP_OKAY;
            if (st_r.awAddr == REG_CTRL_OFS) begin
                if (st_r.wStrb[0]) begin
                    st_nxt.ctrlRxOnly = st_r.wData[CTRL_RXONLY_BIT];
                end
            end else if (st_r.awAddr == REG_STATUS_OFS) begin
                if (st_r.wStrb[0] && st_r.wData[STAT_TOSEEN_BIT]) begin
                    st_nxt.toSeen = 1'b0;
                end
            end else begin
                st_nxt.bResp = RESP_SLVERR;
            end
        end
        if (st_nxt.domTo && !st_r.domTo) begin
            st_nxt.toSeen = 1'b1;
        end
        // Read channel
        if (st_r.rValid && axiReq.rready) begin
            st_nxt.rValid = 1'b0;
        end
        if (arHs) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = RESP_OKAY;
            if (axiReq.araddr == REG_CTRL_OFS) begin
                st_nxt.rData = RDATA_ZERO;
                st_nxt.rData[CTRL_RXONLY_BIT] = st_r.ctrlRxOnly;
            end else if (axiReq.araddr == REG_STATUS_OFS) begin
                st_nxt.rData = statusWord;
            end else begin
                st_nxt.rData = RDATA_ZERO;
                st_nxt.rResp = RESP_SLVERR;
            end
        end
    end

    // State register, reset to power-down with all drivers off
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.mode <= MODE_PWRDN;
            st_r.txdPrev <= 1'b1;
            st_r.ctrlRxOnly <= CTRL_RXONLY_RST;
            st_r.rxd <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign rxdOut = st_r.rxd;
    assign afeOut = st_r.afe;
    always_comb begin
        axiRsp.awready = ~st_r.awSeen & ~st_r.bValid;
        axiRsp.wready = ~st_r.wSeen & ~st_r.bValid;
        axiRsp.bvalid = st_r.bValid;
        axiRsp.bresp = st_r.bResp;
        axiRsp.arready = ~st_r.rValid;
        axiRsp.rvalid = st_r.rValid;
        axiRsp.rdata = st_r.rData;
        axiRsp.rresp = st_r.rResp;
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_pwrdn_on_vio: assert property (
        !vioS |=> st_r.mode == MODE_PWRDN && !st_r.afe.rxOn && !st_r.afe.txEnable)
        else $error("digital supply loss did not power down");

    chk_power_up_mode: assert property (
        st_r.mode == MODE_PWRDN && vioS |=>
        st_r.mode == (!$past(vccS) ? MODE_FORCED :
                      ($past(selHigh) ? MODE_RXONLY : MODE_NORMAL)))
        else $error("wrong mode after power-up");

    chk_rxonly_entry: assert property (
        st_r.mode == MODE_NORMAL && vioS && vccS && selHigh |=> st_r.mode == MODE_RXONLY)
        else $error("mode select high did not leave normal mode");

    chk_entry_needs_vcc: assert property (
        $changed(st_r.mode) && (st_r.mode == MODE_NORMAL || st_r.mode == MODE_RXONLY)
        |-> $past(vccS))
        else $error("entered a transmit-capable mode without transmitter supply");

    chk_vcc_loss: assert property (
        (st_r.mode == MODE_NORMAL || st_r.mode == MODE_RXONLY) && vioS && !vccS
        |=> st_r.mode == MODE_FORCED && !st_r.afe.txEnable && st_r.afe.biasGnd)
        else $error("transmitter supply loss not handled");

    chk_forced_return: assert property (
        st_r.mode == MODE_FORCED && vioS && vccS
        |=> st_r.mode == ($past(selHigh) ? MODE_RXONLY : MODE_NORMAL))
        else $error("wrong mode when transmitter supply returned");

    chk_timeout_set: assert property (
        $rose(st_r.domTo) |-> $past(st_r.domCnt) == DOM_LIM && !$past(txdIn)
        && !st_r.afe.txEnable)
        else $error("dominant timeout set at the wrong count");

    chk_timeout_release: assert property (
        $fell(st_r.domTo) |-> $past(txdIn) && !$past(st_r.txdPrev))
        else $error("timeout released without a txd rising edge");

    chk_ot_gates_tx: assert property (
        st_r.mode == MODE_NORMAL && otS && vioS && vccS && !selHigh
        |=> st_r.mode == MODE_NORMAL && !st_r.afe.txEnable)
        else $error("overtemperature did not gate the transmitter");

    chk_rx_follows_bus: assert property (
        vioS && st_r.mode != MODE_PWRDN |=> st_r.rxd == !$past(busDominantIn))
        else $error("receive output does not follow the bus");

    chk_bvalid_holds: assert property (
        st_r.bValid && !axiReq.bready |=> st_r.bValid)
        else $error("write response dropped before bready");

    cov_normal_to_rxonly: cover property (
        st_r.mode == MODE_NORMAL ##1 st_r.mode == MODE_RXONLY);
    cov_dom_timeout: cover property ($rose(st_r.domTo));
    cov_forced_to_normal: cover property (
        st_r.mode == MODE_FORCED ##1 st_r.mode == MODE_NORMAL);
    cov_ot_release: cover property (
        st_r.mode == MODE_NORMAL && otS ##1 !otS [*2] ##1 st_r.afe.txEnable);

endmodule : cmfs_ctrl

//--- design/cmfs_pkg.sv
// Purpose: Shared constants and types for the CAN transceiver mode and fail-safe controller
// Assumes: 250 MHz mclk, AXI4-Lite register access with 32-bit data
// Notes: Mode codes, register map, timeout figures and bus carriers live here
package cmfs_pkg;

    // Operating modes of the transceiver
    typedef enum logic [1:0] {
        MODE_PWRDN  = 2'b00, // Digital supply absent, all off
        MODE_NORMAL = 2'b01, // Transmit and receive
        MODE_RXONLY = 2'b10, // Receive only, selected by mode select
        MODE_FORCED = 2'b11  // Receive only, transmitter supply absent
    } cmfs_mode_e;

    // Clock and dominant timeout figures
    localparam int CLK_PERIOD_NS = 4;
    localparam int DOM_TO_MIN_MS = 1;
    localparam int DOM_TO_MAX_MS = 4;
    localparam int NS_PER_MS = 1_000_000;
    // Least time rounds up to whole cycles
    localparam int DOM_TO_CYCLES = (DOM_TO_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DOM_CNT_W = 18;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h04;
    // Control fields
    localparam int CTRL_RXONLY_BIT = 0;
    localparam logic CTRL_RXONLY_RST = 1'b0;
    // Status fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_TXEN_BIT = 2;
    localparam int STAT_DOMTO_BIT = 3;
    localparam int STAT_OT_BIT = 4;
    localparam int STAT_TOSEEN_BIT = 5;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Synchroniser reset values: supplies absent, mode select low, no overtemperature
    localparam logic [3:0] SYNC_RST_VAL = 4'h0;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } cmfs_axi_req_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cmfs_axi_rsp_s;

    // Analog front end controls
    typedef struct packed {
        logic txEnable;  // Transmitter connected
        logic txDrive;   // Drive dominant on the bus
        logic rxOn;      // Normal receiver active
        logic biasHalf;  // Bus bias at half transmitter supply
        logic biasGnd;   // Bus bias at ground
    } cmfs_afe_s;

endpackage : cmfs_pkg

//--- design/cmfs_sync.sv
// Purpose: Two-flop synchroniser, one lane per bit
// Assumes: Synchronous active-high reset
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module cmfs_sync
    import cmfs_pkg::*;
#(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    // One pair of flops per lane
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic meta_r; // First stage
            logic stab_r; // Second stage
            // Reset to the pin's idle level, then chain the two stages
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    meta_r <= RST_VAL[i];
                    stab_r <= RST_VAL[i];
                end else begin
                    meta_r <= asyncIn[i];
                    stab_r <= meta_r;
                end
            end
            assign syncOut[i] = stab_r;
        end
    endgenerate

endmodule : cmfs_sync

//--- tb/can_transceiver_mode_failsafe_tb.sv
// Purpose: Self-checking bench for the mode and fail-safe controller
// Assumes: Short dominant timeout, status read over AXI4-Lite
// Notes: Outputs are sampled at the falling edge, inputs driven at the rising edge
`timescale 1ns/10ps
module can_transceiver_mode_failsafe_tb;
    import cmfs_pkg::*;
    localparam int LIMIT = 20; // Short dominant timeout
    // Expected front end: txEnable, txDrive, rxOn, biasHalf, biasGnd
    localparam logic [4:0] AFE_NORM = 5'b10110;
    localparam logic [4:0] AFE_TXOFF = 5'b00110;
    localparam logic [4:0] AFE_FRC = 5'b00101;
    localparam logic [4:0] AFE_OFF = 5'b00000;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic vioGood, vccGood, overTemp, busDom, txd, sel, rxd;
    cmfs_afe_s afe;
    cmfs_axi_req_s axiReq;
    cmfs_axi_rsp_s axiRsp;
    logic [31:0] st, rdat;
    logic [1:0] rsp;
    int miscompares = 0;
    int nChecks = 0;

    always #2 mclk = ~mclk;

    cmfs_ctrl #(.DOM_TO_LIMIT(LIMIT)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .digitalSupplyGood(vioGood), .transmitterSupplyGood(vccGood), .overTempIn(overTemp),
        .modeSelectIn(sel), .txdIn(txd), .rxdOut(rxd), .busDominantIn(busDom),
        .afeOut(afe), .axiReq(axiReq), .axiRsp(axiRsp));
    cmfs_can_host host (.mclk(mclk), .sys_rst(sys_rst), .txdOut(txd), .selOut(sel),
        .rxdIn(rxd));

    // Verdict and end of run
    task tally_and_finish();
        if (miscompares == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task stall();
        miscompares++;
        $display("Error at %0t ns: bus answer never came", $time);
        tally_and_finish();
    endtask : stall

    // Let synchronisers and the mode machine act, then sample
    task settle();
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    // Write with address and data offered together; ready sampled before the edge
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        logic aOk, wOk, bOk;
        bOk = 1'b0;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= s;
        axiReq.bready <= 1'b1;
        for (i = 0; i < 50 && !bOk; i++) begin
            @(negedge mclk);
            aOk = axiReq.awvalid & axiRsp.awready;
            wOk = axiReq.wvalid & axiRsp.wready;
            bOk = axiRsp.bvalid;
            rsp = axiRsp.bresp;
            @(posedge mclk);
            if (aOk) axiReq.awvalid <= 1'b0;
            if (wOk) axiReq.wvalid <= 1'b0;
            if (bOk) axiReq.bready <= 1'b0;
        end
        if (!bOk) stall();
    endtask : axi_wr

    task axi_rd(input logic [7:0] a);
        int i;
        logic aOk, rOk;
        rOk = 1'b0;
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        for (i = 0; i < 50 && !rOk; i++) begin
            @(negedge mclk);
            aOk = axiReq.arvalid & axiRsp.arready;
            rOk = axiRsp.rvalid;
            rdat = axiRsp.rdata;
            rsp = axiRsp.rresp;
            @(posedge mclk);
            if (aOk) axiReq.arvalid <= 1'b0;
            if (rOk) axiReq.rready <= 1'b0;
        end
        if (!rOk) stall();
    endtask : axi_rd

    // Front end first (settled now), then mode from the status word
    task expect_state(input cmfs_mode_e m, input logic [4:0] afeExp, input string what);
        check(afe, afeExp, what);
        axi_rd(REG_STATUS_OFS);
        st = rdat;
        check(st[1:0], m, what);
    endtask : expect_state

    task scen_select();
        host.set_select(1'b1);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(afe, AFE_NORM, "select before sync");
        @(posedge mclk);
        @(negedge mclk);
        check(afe, AFE_TXOFF, "select after sync");
        settle();
        expect_state(MODE_RXONLY, AFE_TXOFF, "select high");
        host.dominant();
        repeat (LIMIT + 4) @(posedge mclk);
        @(negedge mclk);
        expect_state(MODE_RXONLY, AFE_TXOFF, "txd in receive-only");
        check(st[STAT_DOMTO_BIT], 1'b0, "no timeout off normal");
        host.release_tx();
        host.set_select(1'b0);
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "select low");
    endtask : scen_select

    task scen_vcc();
        @(posedge mclk);
        vccGood <= 1'b0;
        busDom <= 1'b1;
        settle();
        expect_state(MODE_FORCED, AFE_FRC, "vcc lost");
        check(rxd, 1'b0, "forced receive");
        @(posedge mclk);
        vccGood <= 1'b1;
        busDom <= 1'b0;
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "vcc back, select low");
        @(posedge mclk);
        vccGood <= 1'b0;
        host.set_select(1'b1);
        settle();
        expect_state(MODE_FORCED, AFE_FRC, "select while forced");
        @(posedge mclk);
        vccGood <= 1'b1;
        settle();
        expect_state(MODE_RXONLY, AFE_TXOFF, "vcc back, select high");
        host.set_select(1'b0);
        settle();
    endtask : scen_vcc

    task scen_power();
        @(posedge mclk);
        vioGood <= 1'b0;
        busDom <= 1'b1;
        settle();
        expect_state(MODE_PWRDN, AFE_OFF, "vio lost");
        check(rxd, 1'b1, "receiver off");
        host.set_select(1'b1);
        settle();
        expect_state(MODE_PWRDN, AFE_OFF, "select unpowered");
        @(posedge mclk);
        vioGood <= 1'b1;
        busDom <= 1'b0;
        settle();
        expect_state(MODE_RXONLY, AFE_TXOFF, "power up select high");
        @(posedge mclk);
        vioGood <= 1'b0;
        vccGood <= 1'b0;
        settle();
        @(posedge mclk);
        vioGood <= 1'b1;
        settle();
        expect_state(MODE_FORCED, AFE_FRC, "power up no vcc");
        host.set_select(1'b0);
        @(posedge mclk);
        vccGood <= 1'b1;
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "back to normal");
    endtask : scen_power

    task scen_timeout();
        @(posedge mclk);
        busDom <= 1'b1;
        host.dominant();
        repeat (LIMIT - 1) @(posedge mclk);
        @(negedge mclk);
        check(afe, 5'b11110, "dominant before limit");
        @(posedge mclk);
        @(negedge mclk);
        expect_state(MODE_NORMAL, AFE_TXOFF, "dominant timeout");
        check(st[STAT_DOMTO_BIT], 1'b1, "timeout flag");
        check(rxd, 1'b0, "receiver during timeout");
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        check(afe, AFE_TXOFF, "still low, still off");
        host.release_tx();
        @(posedge mclk);
        busDom <= 1'b0;
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "released by rising txd");
        check(st[STAT_TOSEEN_BIT], 1'b1, "timeout seen");
    endtask : scen_timeout

    task scen_overtemp();
        @(posedge mclk);
        overTemp <= 1'b1;
        settle();
        expect_state(MODE_NORMAL, AFE_TXOFF, "hot in normal");
        @(posedge mclk);
        overTemp <= 1'b0;
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "cooled down");
    endtask : scen_overtemp

    task scen_regs();
        axi_wr(REG_CTRL_OFS, 32'h0000_0001, 4'hF);
        check(rsp, RESP_OKAY, "ctrl write");
        settle();
        expect_state(MODE_RXONLY, AFE_TXOFF, "register receive-only");
        axi_wr(REG_CTRL_OFS, 32'h0000_0000, 4'hF);
        axi_wr(8'h08, 32'hFFFF_FFFF, 4'hF);
        check(rsp, RESP_SLVERR, "unmapped write");
        axi_rd(8'h08);
        check(rsp, RESP_SLVERR, "unmapped read");
        check(rdat, RDATA_ZERO, "unmapped data");
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "register normal");
        // Lane 0 strobe off: the request bit must not land
        axi_wr(REG_CTRL_OFS, 32'h0000_0001, 4'hE);
        check(rsp, RESP_OKAY, "masked ctrl write");
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "masked write ignored");
        // Write one clears the sticky timeout record left by the timeout scenario
        axi_wr(REG_STATUS_OFS, 32'h0000_0020, 4'h1);
        axi_rd(REG_STATUS_OFS);
        check(rdat[STAT_TOSEEN_BIT], 1'b0, "timeout seen cleared");
    endtask : scen_regs

    // Main sequence
    initial begin
        axiReq = '0;
        vioGood = 1'b0;
        vccGood = 1'b0;
        overTemp = 1'b0;
        busDom = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        vioGood <= 1'b1;
        vccGood <= 1'b1;
        settle();
        expect_state(MODE_NORMAL, AFE_NORM, "open pins");
        scen_select();
        scen_vcc();
        scen_power();
        scen_timeout();
        scen_overtemp();
        scen_regs();
        tally_and_finish();
    end
endmodule : can_transceiver_mode_failsafe_tb

//--- tb/cmfs_can_host.sv
// Purpose: Behavioural CAN protocol controller on the far side of the transceiver
// Assumes: Bench calls the tasks; pins change just after a rising edge
// Notes: Starts with open-pin levels, select low and transmit recessive
`timescale 1ns/10ps
module cmfs_can_host
    import cmfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Transceiver logic pins
    output logic txdOut,
    output logic selOut,
    input wire logic rxdIn
);
    // Open-pin levels until commanded otherwise
    initial begin
        txdOut = 1'b1;
        selOut = 1'b0;
    end

    // Select receive-only or normal operation
    task set_select(input logic v);
        @(posedge mclk);
        selOut <= v;
    endtask : set_select

    // Start a dominant level that is held until released
    task dominant();
        @(posedge mclk);
        txdOut <= 1'b0;
    endtask : dominant

    // A recessive edge is the only way to free a timed-out transmitter
    task release_tx();
        @(posedge mclk);
        txdOut <= 1'b1;
    endtask : release_tx
endmodule : cmfs_can_host
